// ==== rtl/boot_responder.sv ====
/*
 * Target-side responder of the serial boot protocol: mode detection
 * from the first byte's edges, acknowledge generation, password check,
 * flash byte sum and checksum. Replies pass through an 8-word FIFO.
 * Assumes a byte receiver and transmitter outside, a flash read port
 * with one-cycle latency, and an external erase engine.
 */
// What this block does
// - Ack upper nibble is current command's
// - Bit3 receive error, bit0 invalid, bits1-2 zero
// - No receive error in clocked mode
// - Mode ack 0x86 async, 0x30 clocked
// - Async without baud: halt, no ack
// - Echo valid commands 0x10 to 0x40
// - Bad command ack keeps previous nibble
// - Checksum ack low nibble 8/1/0
// - Erase acks 0x54, then 0x4F/0x4C
// - Timestamp first byte edges from first fall
// - Async when first low not longer
// - Any clocked first byte answered 0x30
// - Check 12-byte password after 0x10 echo
// - Uniform non-FF password area: ack 0x11
// - Bytes 1-12 compared, error on 13th
// - Password checked regardless of security
// - Sum all flash into 16 bits, high first
// - Checksum is two's complement of byte sum
// - Checksum appended to sum data
// - After receive error, wait for command
`timescale 1ns/100ps
module boot_responder
    import boot_resp_pkg::*;
#(
    parameter int FLASH_BYTES = FLASH_BYTES_KB * 1024,
    parameter int FIFO_DEPTH  = 8
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    rx_pin,
    input  wire logic                    baud_ok,
    input  wire rx_byte_t                rx_byte,
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              pwd_data,
    input  wire logic [7:0]              flash_data,
    input  wire erase_result_t           erase_result,
    input  wire logic                    erase_done,
    input  wire logic                    tx_ready,
    output logic [7:0]                   tx_data,
    output logic                         tx_valid,
    output logic                         rx_enable,
    output logic                         clocked_mode,
    output logic [$clog2(PASSWORD_BYTES)-1:0] pwd_addr,
    output logic [FLASH_ADDR_W-1:0]      flash_addr,
    output logic                         erase_start,
    output logic                         halted
);
    initial begin
        if (FLASH_BYTES < 4 || FLASH_BYTES > (1 << FLASH_ADDR_W))
            $error("FLASH_BYTES out of range");
    end

    // -------------------------------------------------------------------
    // Pin synchroniser and edge timestamps
    // -------------------------------------------------------------------
    logic [2:0]             pin_sync;
    logic                   pin_level;
    logic [TIMER_WIDTH-1:0] timer;
    logic [TIMER_WIDTH-1:0] stamp [EDGE_COUNT];
    logic [2:0]             edge_cnt;
    logic                   mode_decided;

    // Three flops; a change counts when stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync  <= 3'h7;
            pin_level <= 1'b1;
        end else begin
            pin_sync <= {pin_sync[1:0], rx_pin};
            if (pin_sync[1] == pin_sync[2]) pin_level <= pin_sync[2];
        end
    end

    logic pin_change;
    assign pin_change = (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_level);

    // Free timer; edges stamped from the first fall onwards
    always_ff @(posedge clk) begin
        if (rst) begin
            timer    <= '0;
            edge_cnt <= '0;
        end else begin
            timer <= timer + 1'b1;
            if (!mode_decided && pin_change && edge_cnt < 3'(EDGE_COUNT) &&
                (edge_cnt != 3'h0 || pin_level)) begin
                stamp[edge_cnt[1:0]] <= timer;
                edge_cnt             <= edge_cnt + 1'b1;
            end
        end
    end

    // First low interval and final low interval
    logic [TIMER_WIDTH-1:0] first_low;
    logic [TIMER_WIDTH-1:0] final_low;
    assign first_low = stamp[1] - stamp[0];
    assign final_low = stamp[3] - stamp[2];

    // -------------------------------------------------------------------
    // Protocol state
    // -------------------------------------------------------------------
    state_t                 state;
    logic [3:0]             cur_cmd;
    logic [3:0]             pwd_idx;
    logic                   pwd_mismatch;
    logic                   pwd_uniform;
    logic [7:0]             pwd_first;
    logic [7:0]             csum_acc;
    logic [SUM_WIDTH-1:0]   flash_sum;
    logic [FLASH_ADDR_W:0]  sum_cnt;
    logic [1:0]             sum_tx_idx;
    logic [7:0]             push_data;
    logic                   push_valid;
    logic                   push_ready;

    // Ack assembly: command nibble plus error bits, bits 1-2 zero
    function automatic logic [7:0] make_ack(input logic [3:0] nib,
                                            input logic rx_err,
                                            input logic inval);
        make_ack = {nib, rx_err, 2'b00, inval};
    endfunction

    // Known command codes
    function automatic logic is_cmd(input logic [7:0] b);
        is_cmd = (b[3:0] == 4'h0) && (b[7:4] >= CMD_RAM_XFER) &&
                 (b[7:4] <= CMD_CHIP_ERASE);
    endfunction

    logic rx_err_eff;
    assign rx_err_eff = rx_byte.rx_err && !clocked_mode;

    // Main sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= ST_MODE_WAIT;
            cur_cmd      <= RESET_CMD[7:4];
            mode_decided <= 1'b0;
            clocked_mode <= 1'b0;
            rx_enable    <= 1'b0;
            halted       <= 1'b0;
            push_valid   <= 1'b0;
            push_data    <= '0;
            pwd_idx      <= '0;
            pwd_mismatch <= 1'b0;
            pwd_uniform  <= 1'b1;
            pwd_first    <= '0;
            csum_acc     <= '0;
            flash_sum    <= '0;
            sum_cnt      <= '0;
            sum_tx_idx   <= '0;
            erase_start  <= 1'b0;
        end else begin
            erase_start <= 1'b0;
            if (push_valid && push_ready) push_valid <= 1'b0;
            case (state)
                ST_MODE_WAIT: begin
                    if (edge_cnt == 3'(EDGE_COUNT)) begin
                        mode_decided <= 1'b1;
                        clocked_mode <= first_low > final_low;
                        state        <= ST_MODE_ACK;
                    end
                end
                ST_MODE_ACK: begin
                    if (!clocked_mode && !baud_ok) begin
                        halted <= 1'b1;
                        state  <= ST_HALT;
                    end else if (!push_valid) begin
                        push_data  <= clocked_mode ? ACK_CLOCKED : ACK_ASYNC;
                        push_valid <= 1'b1;
                        rx_enable  <= 1'b1;
                        state      <= ST_CMD_WAIT;
                    end
                end
                ST_CMD_WAIT: begin
                    if (rx_valid && !push_valid) begin
                        push_valid <= 1'b1;
                        if (rx_err_eff) begin
                            push_data <= make_ack(cur_cmd, 1'b1, 1'b0);
                        end else if (!is_cmd(rx_byte.data)) begin
                            push_data <= make_ack(cur_cmd, 1'b0, 1'b1);
                        end else begin
                            push_data <= rx_byte.data;
                            cur_cmd   <= rx_byte.data[7:4];
                            state     <= ST_CMD_ACK;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    pwd_idx      <= '0;
                    pwd_mismatch <= 1'b0;
                    pwd_uniform  <= 1'b1;
                    csum_acc     <= '0;
                    flash_sum    <= '0;
                    sum_cnt      <= '0;
                    sum_tx_idx   <= '0;
                    case (cur_cmd)
                        CMD_RAM_XFER:   state <= ST_PWD_RX;
                        CMD_FLASH_SUM:  state <= ST_SUM_RUN;
                        CMD_CHIP_ERASE: state <= ST_ERASE_EN;
                        default:        state <= ST_CMD_WAIT;
                    endcase
                end
                ST_PWD_RX: begin
                    if (rx_valid) begin
                        csum_acc <= csum_acc + rx_byte.data;
                        if (rx_byte.data != pwd_data) pwd_mismatch <= 1'b1;
                        if (pwd_idx == 4'h0) pwd_first <= pwd_data;
                        else if (pwd_data != pwd_first) pwd_uniform <= 1'b0;
                        if (pwd_idx == 4'(PASSWORD_BYTES - 1)) state <= ST_CSUM_ACK;
                        pwd_idx <= pwd_idx + 1'b1;
                    end
                end
                ST_CSUM_ACK: begin
                    if (rx_valid && !push_valid) begin
                        push_valid <= 1'b1;
                        state      <= ST_CMD_WAIT;
                        if (rx_err_eff)
                            push_data <= {cur_cmd, LOW_RX_ERR};
                        else if ((pwd_uniform && pwd_first != ERASED_BYTE) ||
                                 pwd_mismatch ||
                                 (8'(csum_acc + rx_byte.data) != 8'h00))
                            push_data <= {cur_cmd, LOW_INVAL};
                        else
                            push_data <= {cur_cmd, LOW_OK};
                    end
                end
                ST_SUM_RUN: begin
                    // Flash read has one cycle latency; sum_cnt leads by one
                    if (sum_cnt != '0)
                        flash_sum <= flash_sum + SUM_WIDTH'(flash_data);
                    if (sum_cnt == (FLASH_ADDR_W+1)'(FLASH_BYTES)) state <= ST_SUM_TX;
                    else sum_cnt <= sum_cnt + 1'b1;
                end
                ST_SUM_TX: begin
                    if (!push_valid) begin
                        push_valid <= 1'b1;
                        sum_tx_idx <= sum_tx_idx + 1'b1;
                        case (sum_tx_idx)
                            2'h0: push_data <= flash_sum[15:8];
                            2'h1: push_data <= flash_sum[7:0];
                            default: begin
                                push_data <= 8'(8'h00 - (flash_sum[15:8] + flash_sum[7:0]));
                                state     <= ST_CMD_WAIT;
                            end
                        endcase
                    end
                end
                ST_ERASE_EN: begin
                    if (rx_valid && !push_valid) begin
                        push_valid <= 1'b1;
                        if (rx_err_eff) begin
                            push_data <= make_ack(cur_cmd, 1'b1, 1'b0);
                            state     <= ST_CMD_WAIT;
                        end else if (rx_byte.data != ERASE_ENABLE) begin
                            push_data <= make_ack(cur_cmd, 1'b0, 1'b1);
                            state     <= ST_CMD_WAIT;
                        end else begin
                            push_data   <= ERASE_ENABLE;
                            erase_start <= 1'b1;
                            state       <= ST_ERASE_RUN;
                        end
                    end
                end
                ST_ERASE_RUN: begin
                    if (erase_done && !push_valid) begin
                        push_valid <= 1'b1;
                        push_data  <= erase_result.ok && !erase_result.abnormal ?
                                      ERASE_DONE_OK : ERASE_DONE_BAD;
                        state      <= ST_CMD_WAIT;
                    end
                end
                ST_HALT: state <= ST_HALT;
                default: state <= ST_MODE_WAIT;
            endcase
        end
    end

    // Password and flash read addresses
    assign pwd_addr   = pwd_idx[$clog2(PASSWORD_BYTES)-1:0];
    assign flash_addr = sum_cnt[FLASH_ADDR_W-1:0];

    // -------------------------------------------------------------------
    // Reply FIFO
    // -------------------------------------------------------------------
    boot_tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_ack_bits_zero: assert property (@(posedge clk) disable iff (rst)
        push_valid && state != ST_SUM_TX && $past(state) != ST_SUM_TX &&
        !$past(state == ST_MODE_ACK) && !$past(state == ST_ERASE_RUN) &&
        !$past(state == ST_ERASE_EN) |-> push_data[2:1] == 2'b00)
        else $error("ack bits 1-2 not zero");
    a_clocked_no_rxerr: assert property (@(posedge clk) disable iff (rst)
        $rose(push_valid) && clocked_mode && $past(state) == ST_CMD_WAIT
        |-> !push_data[ACK_RX_ERR_BIT])
        else $error("receive error flagged in clocked mode");
    a_mode_ack_code: assert property (@(posedge clk) disable iff (rst)
        state == ST_MODE_ACK && !push_valid && (clocked_mode || baud_ok)
        |=> push_data == (clocked_mode ? ACK_CLOCKED : ACK_ASYNC))
        else $error("wrong mode ack");
    a_halt_silent: assert property (@(posedge clk) disable iff (rst)
        state == ST_HALT |-> !push_valid [*4])
        else $error("ack sent after halt");
    a_cmd_echo: assert property (@(posedge clk) disable iff (rst)
        state == ST_CMD_WAIT && rx_valid && !push_valid && !rx_err_eff &&
        is_cmd(rx_byte.data) |=> push_data == $past(rx_byte.data) && state == ST_CMD_ACK)
        else $error("command not echoed");
    a_bad_cmd_nib: assert property (@(posedge clk) disable iff (rst)
        state == ST_CMD_WAIT && rx_valid && !push_valid && !is_cmd(rx_byte.data)
        |=> push_data[7:4] == $past(cur_cmd) && state == ST_CMD_WAIT)
        else $error("bad command ack nibble");
    a_mode_first: assert property (@(posedge clk) disable iff (rst)
        !mode_decided |-> state == ST_MODE_WAIT && !rx_enable)
        else $error("command stage before mode");
    a_sum_order: assert property (@(posedge clk) disable iff (rst)
        state == ST_SUM_TX && sum_tx_idx == 2'h0 && !push_valid
        |=> push_data == flash_sum[15:8])
        else $error("sum high byte not first");

    // Checksum ack keeps the command nibble, bits 1-2 clear, back to command wait
    a_csum_ack_form: assert property (@(posedge clk) disable iff (rst)
        state == ST_CSUM_ACK && rx_valid && !push_valid
        |=> push_valid && push_data[7:4] == $past(cur_cmd) && push_data[2:1] == 2'b00 &&
            state == ST_CMD_WAIT)
        else $error("checksum ack malformed");

    // Accepted erase enable is echoed and starts the erase engine
    a_erase_echo: assert property (@(posedge clk) disable iff (rst)
        state == ST_ERASE_EN && rx_valid && !push_valid && !rx_err_eff &&
        rx_byte.data == ERASE_ENABLE |=> push_data == ERASE_ENABLE && erase_start)
        else $error("erase enable not echoed");
endmodule

// ==== rtl/boot_resp_pkg.sv ====
/*
 * Package for the serial boot protocol responder: acknowledge codes,
 * command codes, protocol byte counts and carrier structs.
 * Assumes the includer compiles it before the design file.
 */
package boot_resp_pkg;

    // -------------------------------------------------------------------
    // Acknowledge and command codes
    // -------------------------------------------------------------------
    localparam logic [7:0] ACK_ASYNC      = 8'h86;
    localparam logic [7:0] ACK_CLOCKED    = 8'h30;
    localparam logic [3:0] CMD_RAM_XFER   = 4'h1;
    localparam logic [3:0] CMD_FLASH_SUM  = 4'h2;
    localparam logic [3:0] CMD_PROD_INFO  = 4'h3;
    localparam logic [3:0] CMD_CHIP_ERASE = 4'h4;
    localparam logic [7:0] ERASE_ENABLE   = 8'h54;
    localparam logic [7:0] ERASE_DONE_OK  = 8'h4F;
    localparam logic [7:0] ERASE_DONE_BAD = 8'h4C;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;

    // -------------------------------------------------------------------
    // Acknowledge field positions
    // -------------------------------------------------------------------
    localparam int ACK_RX_ERR_BIT = 3;
    localparam int ACK_INVAL_BIT  = 0;
    localparam logic [3:0] LOW_RX_ERR = 4'h8;
    localparam logic [3:0] LOW_INVAL  = 4'h1;
    localparam logic [3:0] LOW_OK     = 4'h0;

    // -------------------------------------------------------------------
    // Protocol counts
    // -------------------------------------------------------------------
    localparam int PASSWORD_BYTES  = 12;
    localparam int RAM_HDR_BYTES   = 0;
    localparam int EDGE_COUNT      = 4;
    localparam int TIMER_WIDTH     = 16;
    localparam int SUM_WIDTH       = 16;
    localparam int FLASH_ADDR_W    = 19;
    localparam int FLASH_BYTES_KB  = 512;
    localparam logic [7:0] RESET_CMD = 8'h00;

    // -------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic       rx_err;
    } rx_byte_t;

    typedef struct packed {
        logic       ok;
        logic       abnormal;
    } erase_result_t;

    // Responder states, Gray coded along the usual path
    typedef enum logic [3:0] {
        ST_MODE_WAIT  = 4'b0000,
        ST_MODE_ACK   = 4'b0001,
        ST_CMD_WAIT   = 4'b0011,
        ST_CMD_ACK    = 4'b0010,
        ST_PWD_RX     = 4'b0110,
        ST_CSUM_ACK   = 4'b0111,
        ST_SUM_RUN    = 4'b0101,
        ST_SUM_TX     = 4'b0100,
        ST_ERASE_EN   = 4'b1100,
        ST_ERASE_RUN  = 4'b1101,
        ST_HALT       = 4'b1111
    } state_t;

endpackage

// ==== rtl/boot_tx_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
module boot_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end

    // Full and empty from pointer difference
    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ==== tb/boot_ctrl_model.sv ====
/*
 * Model of the programming controller: sends the mode byte on the serial pin,
 * sends bytes on the byte strobe and collects the replies.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/100ps
module boot_ctrl_model
    import boot_resp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       slow,
    output logic            rx_pin,
    output rx_byte_t        rx_byte,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] got[$];

    initial begin
        rx_pin = 1'b1;
        rx_byte = '0;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    // ------------------------------------------------------------------
    // Mode byte, start bit first, then data LSB first
    // ------------------------------------------------------------------
    task automatic send_mode(input logic [7:0] b, input int bit_cyc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= fr[i];
            repeat (bit_cyc) @(posedge clk);
        end
    endtask

    // One byte strobe, then the data lines turn to garbage
    task automatic send_byte(input logic [7:0] b, input logic err);
        rx_byte <= '{data: b, rx_err: err};
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        repeat (3) @(posedge clk);
    endtask

    // Reply sink, stalls every other cycle when slow
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the boot responder with a controller model.
 * Assumes a password store and a flash image modelled here.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb
    import boot_resp_pkg::*;
;
    localparam int FB = 16;
    typedef struct {logic [7:0] cmd; logic err; logic [7:0] exp;} row_t;
    row_t rows[4] = '{'{8'h30, 1'b0, 8'h30}, '{8'h77, 1'b0, 8'h31},
                      '{8'h30, 1'b1, 8'h38}, '{8'hE0, 1'b0, 8'h31}};
    logic clk = 1'b0, rst = 1'b1, baud_ok = 1'b1, slow = 1'b0, uniform = 1'b0, bad = 1'b0;
    logic rx_pin, rx_valid, tx_ready, tx_valid, rx_enable, clocked_mode, erase_start, halted;
    logic erase_done = 1'b0;
    erase_result_t erase_result = '0;
    rx_byte_t rx_byte;
    logic [7:0] pwd_data, tx_data, ack, cs, pb;
    logic [7:0] flash_data = 8'h00;
    logic [3:0] pwd_addr;
    logic [18:0] flash_addr;
    logic [15:0] sum;
    int fail_count = 0, checked = 0, starts = 0;

    always #25 clk = ~clk;

    // Password store, flash image and erase engine
    assign pwd_data = uniform ? 8'h5A : 8'h30 + {4'h0, pwd_addr};
    always @(posedge clk) begin
        flash_data <= flash_addr[7:0] * 8'h03 + 8'h11;
        erase_done <= erase_start;
        erase_result <= '{ok: !bad, abnormal: bad};
        if (erase_start === 1'b1) starts++;
    end

    boot_responder #(.FLASH_BYTES(FB), .FIFO_DEPTH(8)) i_dut (
        .clk(clk), .rst(rst), .rx_pin(rx_pin), .baud_ok(baud_ok), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .pwd_data(pwd_data), .flash_data(flash_data),
        .erase_result(erase_result), .erase_done(erase_done), .tx_ready(tx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .rx_enable(rx_enable),
        .clocked_mode(clocked_mode), .pwd_addr(pwd_addr), .flash_addr(flash_addr),
        .erase_start(erase_start), .halted(halted));

    boot_ctrl_model i_ctrl (
        .clk(clk), .slow(slow), .rx_pin(rx_pin), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    task automatic stop_test;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded wait for a reply, as a controller gives up on silence
    task automatic get_ack(output logic [7:0] b);
        int n;
        n = 0;
        while (i_ctrl.got.size() == 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        b = 8'hXX;
        if (i_ctrl.got.size() != 0) b = i_ctrl.got.pop_front();
    endtask

    task automatic cmd_ack(input logic [7:0] c, input logic e, input logic [7:0] x);
        i_ctrl.send_byte(c, e);
        get_ack(ack);
        `CHK(ack, x)
    endtask

    task automatic do_reset(input logic [7:0] mb, input int bc);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(rx_enable, 1'b0)
        `CHK(tx_valid, 1'b0)
        i_ctrl.got.delete();
        i_ctrl.send_mode(mb, bc);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        stop_test;
    end

    initial begin
        @(posedge clk);
        do_reset(ACK_ASYNC, 8);
        get_ack(ack);
        `CHK(ack, ACK_ASYNC)
        `CHK(clocked_mode, 1'b0)
        `CHK(rx_enable, 1'b1)
        foreach (rows[i]) cmd_ack(rows[i].cmd, rows[i].err, rows[i].exp);
        $display("command table done");
        // Flash sum with a stalling sink
        slow <= 1'b1;
        cmd_ack(8'h20, 1'b0, 8'h20);
        sum = 16'h0000;
        for (int a = 0; a < FB; a++) sum += {8'h00, 8'(a * 3 + 17)};
        get_ack(ack);
        `CHK(ack, sum[15:8])
        get_ack(ack);
        `CHK(ack, sum[7:0])
        cs = 8'h00 - sum[15:8] - sum[7:0];
        get_ack(ack);
        `CHK(ack, cs)
        slow <= 1'b0;
        $display("flash sum done");
        // Good password, wrong last byte, uniform area, receive error on checksum
        for (int k = 0; k < 4; k++) begin
            uniform <= (k == 2);
            cmd_ack(8'h10, 1'b0, 8'h10);
            cs = 8'h00;
            for (int j = 0; j < 12; j++) begin
                pb = (k == 2) ? 8'h5A : 8'h30 + 8'(j) + ((k == 1 && j == 11) ? 8'h01 : 8'h00);
                cs -= pb;
                i_ctrl.send_byte(pb, 1'b0);
            end
            cmd_ack(cs, k == 3, (k == 0) ? 8'h10 : (k == 3) ? 8'h18 : 8'h11);
        end
        uniform <= 1'b0;
        $display("password done");
        // Erase, normal then abnormal completion
        for (int k = 0; k < 2; k++) begin
            bad <= (k == 1);
            cmd_ack(8'h40, 1'b0, 8'h40);
            cmd_ack(ERASE_ENABLE, 1'b0, ERASE_ENABLE);
            get_ack(ack);
            `CHK(ack, (k == 1) ? ERASE_DONE_BAD : ERASE_DONE_OK)
        end
        // Wrong enable byte: invalid ack, no erase started
        cmd_ack(8'h40, 1'b0, 8'h40);
        cmd_ack(8'h55, 1'b0, 8'h41);
        `CHK(starts, 2)
        $display("erase done");
        // Clocked mode at a sixteenth of the rate, receive error ignored
        do_reset(ACK_CLOCKED, 128);
        get_ack(ack);
        `CHK(ack, ACK_CLOCKED)
        `CHK(clocked_mode, 1'b1)
        cmd_ack(8'h30, 1'b1, 8'h30);
        // Async without a usable baud rate: silent halt
        baud_ok <= 1'b0;
        do_reset(ACK_ASYNC, 8);
        i_ctrl.send_byte(8'h30, 1'b0);
        repeat (20) @(posedge clk);
        `CHK(halted, 1'b1)
        `CHK(rx_enable, 1'b0)
        `CHK(i_ctrl.got.size(), 0)
        $display("mode tests done");
        stop_test;
    end
endmodule
